/* File: include/uhp_pkg.sv */
package uhp_pkg;
  // Host channels served by the summary and mask
  localparam int NUM_CH = 8;
  localparam int ADDR_W = 12;
  // Register byte offsets
  localparam logic [11:0] OFF_CH_SUMMARY = 12'h414;
  localparam logic [11:0] OFF_CH_ENABLE = 12'h418;
  localparam logic [11:0] OFF_PORT_CS = 12'h440;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h480;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h484;
  // Reset values
  localparam logic [31:0] RST_CH_SUMMARY = 32'h0000_0000;
  localparam logic [31:0] RST_CH_ENABLE = 32'h0000_0000;
  localparam logic [31:0] RST_PORT_CS = 32'h0000_0000;
  localparam logic [31:0] RST_IRQ = 32'h0000_0000;
  // Port control and status field positions
  localparam int PCS_CONN_STATE = 0;
  localparam int PCS_CONN_FLAG = 1;
  localparam int PCS_ENABLE = 2;
  localparam int PCS_EN_CHANGE = 3;
  localparam int PCS_RESUME = 6;
  localparam int PCS_SUSPEND = 7;
  localparam int PCS_RESET = 8;
  localparam int PCS_LINE_LO = 10;
  localparam int PCS_POWER = 12;
  localparam int PCS_SPEED_LO = 17;
  // Enumerated speed codes
  localparam logic [1:0] SPEED_NONE = 2'h0;
  localparam logic [1:0] SPEED_FULL = 2'h1;
  localparam logic [1:0] SPEED_LOW = 2'h2;
  // Interrupt status bit positions
  localparam int EV_CONNECT = 0;
  localparam int EV_DISCONNECT = 1;
  localparam int EV_EN_CHANGE = 2;
  localparam int EV_WAKEUP = 3;
  localparam int EV_CHANNEL = 4;
  localparam int NUM_EV = 5;
  // Line must hold steady this long before attach or detach is believed
  localparam int CLK_PERIOD_NS = 50;
  localparam int DEBOUNCE_NS = 2500;
  localparam int DEBOUNCE_CYC = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

/* File: include/uhp_reg_if.sv */
`timescale 1ns/10ps
`default_nettype none
// Register access strobes between the bus slave and the port logic
interface uhp_reg_if;
  logic wr_en;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [1:0] wr_resp;
  logic rd_en;
  logic [11:0] rd_addr;
  logic [31:0] rd_data;
  logic [1:0] rd_resp;
  modport bus (output wr_en, output wr_addr, output wr_data, input wr_resp,
               output rd_en, output rd_addr, input rd_data, input rd_resp);
  modport regs (input wr_en, input wr_addr, input wr_data, output wr_resp,
                input rd_en, input rd_addr, output rd_data, output rd_resp);
endinterface
`default_nettype wire

/* File: hw/uhp_axil_slave.sv */
`timescale 1ns/10ps
`default_nettype none
module uhp_axil_slave (
  input wire logic clk,
  input wire logic rst,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  uhp_reg_if.bus rif
);
  logic aw_held_reg, w_held_reg;
  logic [11:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic aw_take, w_take, wr_fire, ar_take;
  logic aw_held_next, w_held_next, rvalid_next;

  // Address and data may arrive in either order; fire once both are held
  assign aw_take = awvalid & awready;
  assign w_take = wvalid & wready;
  assign wr_fire = aw_held_reg & w_held_reg & ~bvalid;
  assign aw_held_next = (aw_held_reg | aw_take) & ~wr_fire;
  assign w_held_next = (w_held_reg | w_take) & ~wr_fire;
  assign ar_take = arvalid & arready;
  assign rvalid_next = ar_take | (rvalid & ~rready);

  // Partial-word writes never reach the registers
  assign rif.wr_en = wr_fire & (wstrb_reg == 4'hf);
  assign rif.wr_addr = awaddr_reg;
  assign rif.wr_data = wdata_reg;
  assign rif.rd_en = ar_take;
  assign rif.rd_addr = araddr;

  // Write channel
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= uhp_pkg::RESP_OKAY;
      awaddr_reg <= 12'h000;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      awready <= ~aw_held_next;
      wready <= ~w_held_next;
      if (aw_take) awaddr_reg <= awaddr;
      if (w_take) begin
        wdata_reg <= wdata;
        wstrb_reg <= wstrb;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp <= (wstrb_reg == 4'hf) ? rif.wr_resp : uhp_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read channel: data captured and valid raised on the same edge that takes the address
  always_ff @(posedge clk) begin
    if (rst) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= uhp_pkg::RESP_OKAY;
    end else begin
      arready <= ~rvalid_next;
      rvalid <= rvalid_next;
      if (ar_take) begin
        rdata <= rif.rd_data;
        rresp <= rif.rd_resp;
      end
    end
  end
endmodule
`default_nettype wire

/* File: hw/uhp_top.sv */
`timescale 1ns/10ps
`default_nettype none
// How it works
// - A raised channel interrupt sets its bit n in the eight-bit summary.
// - Only channels with their enable mask bit set drive the global channel flag.
// - Port reset, enable change or connect flag raises the global port flag.
// - Speed field 18:17 reports 01 full speed, 10 low speed.
// - Port power bit 12 also gates attach detect and port enable; no supply is driven.
// - Line status bit 10 shows DP level, bit 11 shows DM level.
// - Reset bit 8 starts reset signalling when set, stops when cleared.
// - Writing one to suspend bit 7 puts the port in suspend.
// - Suspend stops frame starts; clears on reset, resume, wakeup or disconnect.
// - Enable sets when reset ends, never by software; disconnect, clear or power off drops it.
// - Connection sets connect flag, cleared by writing one; status shows attachment.
module uhp_top #(
  parameter int NUM_CH = uhp_pkg::NUM_CH,
  parameter int DEBOUNCE_CYC = uhp_pkg::DEBOUNCE_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [NUM_CH-1:0] CH_IRQ,
  input wire logic DP_IN,
  input wire logic DM_IN,
  output logic PORT_RESET_DRV,
  output logic PORT_RESUME_DRV,
  output logic PORT_POWERED,
  output logic SOF_ENABLE,
  output logic HOST_CH_FLAG,
  output logic HOST_PORT_FLAG,
  output logic IRQ
);
  localparam int CNT_W = $clog2(DEBOUNCE_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DEBOUNCE_CYC - 1);

  uhp_reg_if rif ();

  // Set wins over a clear written in the same cycle
  function automatic logic sticky(input logic cur, input logic set, input logic clr);
    sticky = set | (cur & ~clr);
  endfunction

  uhp_axil_slave u_bus (
    .clk(CLK_SYS),
    .rst(RST),
    .awaddr(S_AXI_AWADDR),
    .awvalid(S_AXI_AWVALID),
    .awready(S_AXI_AWREADY),
    .wdata(S_AXI_WDATA),
    .wstrb(S_AXI_WSTRB),
    .wvalid(S_AXI_WVALID),
    .wready(S_AXI_WREADY),
    .bresp(S_AXI_BRESP),
    .bvalid(S_AXI_BVALID),
    .bready(S_AXI_BREADY),
    .araddr(S_AXI_ARADDR),
    .arvalid(S_AXI_ARVALID),
    .arready(S_AXI_ARREADY),
    .rdata(S_AXI_RDATA),
    .rresp(S_AXI_RRESP),
    .rvalid(S_AXI_RVALID),
    .rready(S_AXI_RREADY),
    .rif(rif)
  );

  logic [NUM_CH-1:0] ch_summary_reg;
  logic [NUM_CH-1:0] channel_irq_mask;
  logic dp_meta_reg, dp_sync_reg, dm_meta_reg, dm_sync_reg;
  logic [1:0] line_state;
  logic port_power_bit, port_reset_bit, port_reset_d_reg;
  logic port_resume_bit, port_suspend_bit, port_enable_bit;
  logic connect_state, connect_detected_flag, enable_change_flag;
  logic [1:0] enumerated_speed;
  logic [CNT_W-1:0] debounce_reg;
  logic [uhp_pkg::NUM_EV-1:0] irq_status_reg, irq_mask_reg;
  logic ch_flag_d_reg;
  logic wr_pcs, wr_enable, wr_status, wr_mask;
  logic [31:0] wd;
  logic attached, lines_driven, connect_next, conn_ev, disc_ev;
  logic reset_done, wake_ev, enable_next, enchg_ev;
  logic [uhp_pkg::NUM_EV-1:0] ev;

  // Write decode, one strobe per register except the read-only summary
  assign wd = rif.wr_data;
  assign wr_pcs = rif.wr_en & (rif.wr_addr == uhp_pkg::OFF_PORT_CS);
  assign wr_enable = rif.wr_en & (rif.wr_addr == uhp_pkg::OFF_CH_ENABLE);
  assign wr_status = rif.wr_en & (rif.wr_addr == uhp_pkg::OFF_IRQ_STATUS);
  assign wr_mask = rif.wr_en & (rif.wr_addr == uhp_pkg::OFF_IRQ_MASK);

  // Write answer: the summary accepts writes but keeps no data
  always_comb begin
    case (rif.wr_addr)
      uhp_pkg::OFF_CH_SUMMARY,
      uhp_pkg::OFF_CH_ENABLE,
      uhp_pkg::OFF_PORT_CS,
      uhp_pkg::OFF_IRQ_STATUS,
      uhp_pkg::OFF_IRQ_MASK: rif.wr_resp = uhp_pkg::RESP_OKAY;
      default: rif.wr_resp = uhp_pkg::RESP_DECERR;
    endcase
  end

  // Read multiplexer; unused bits read as zero
  always_comb begin
    rif.rd_data = 32'h0000_0000;
    rif.rd_resp = uhp_pkg::RESP_OKAY;
    case (rif.rd_addr)
      uhp_pkg::OFF_CH_SUMMARY: begin
        rif.rd_data[NUM_CH-1:0] = ch_summary_reg;
      end
      uhp_pkg::OFF_CH_ENABLE: begin
        rif.rd_data[NUM_CH-1:0] = channel_irq_mask;
      end
      uhp_pkg::OFF_PORT_CS: begin
        rif.rd_data[uhp_pkg::PCS_CONN_STATE] = connect_state;
        rif.rd_data[uhp_pkg::PCS_CONN_FLAG] = connect_detected_flag;
        rif.rd_data[uhp_pkg::PCS_ENABLE] = port_enable_bit;
        rif.rd_data[uhp_pkg::PCS_EN_CHANGE] = enable_change_flag;
        rif.rd_data[uhp_pkg::PCS_RESUME] = port_resume_bit;
        rif.rd_data[uhp_pkg::PCS_SUSPEND] = port_suspend_bit;
        rif.rd_data[uhp_pkg::PCS_RESET] = port_reset_bit;
        rif.rd_data[uhp_pkg::PCS_LINE_LO +: 2] = line_state;
        rif.rd_data[uhp_pkg::PCS_POWER] = port_power_bit;
        rif.rd_data[uhp_pkg::PCS_SPEED_LO +: 2] = enumerated_speed;
      end
      uhp_pkg::OFF_IRQ_STATUS: begin
        rif.rd_data[uhp_pkg::NUM_EV-1:0] = irq_status_reg;
      end
      uhp_pkg::OFF_IRQ_MASK: begin
        rif.rd_data[uhp_pkg::NUM_EV-1:0] = irq_mask_reg;
      end
      default: begin
        rif.rd_resp = uhp_pkg::RESP_DECERR;
      end
    endcase
  end

  // Channel flags come from same-clock channel logic, so no synchroniser
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ch_summary_reg <= NUM_CH'(uhp_pkg::RST_CH_SUMMARY);
    end else begin
      ch_summary_reg <= CH_IRQ;
    end
  end

  // Channel enable mask
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      channel_irq_mask <= NUM_CH'(uhp_pkg::RST_CH_ENABLE);
    end else if (wr_enable) begin
      channel_irq_mask <= wd[NUM_CH-1:0];
    end
  end

  // Global channel flag: masked channels never reach it
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      HOST_CH_FLAG <= 1'b0;
      ch_flag_d_reg <= 1'b0;
    end else begin
      HOST_CH_FLAG <= |(ch_summary_reg & channel_irq_mask);
      ch_flag_d_reg <= HOST_CH_FLAG;
    end
  end

  // Data lines are asynchronous pins: two flops before use
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      dp_meta_reg <= 1'b0;
      dp_sync_reg <= 1'b0;
      dm_meta_reg <= 1'b0;
      dm_sync_reg <= 1'b0;
    end else begin
      dp_meta_reg <= DP_IN;
      dp_sync_reg <= dp_meta_reg;
      dm_meta_reg <= DM_IN;
      dm_sync_reg <= dm_meta_reg;
    end
  end

  // Line status, one cycle behind the synchronised pins
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      line_state <= 2'h0;
    end else begin
      line_state <= {dm_sync_reg, dp_sync_reg};
    end
  end

  // Port power is a flag that also gates attach detect and enable; this block drives no supply
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      port_power_bit <= 1'b0;
    end else if (wr_pcs) begin
      port_power_bit <= wd[uhp_pkg::PCS_POWER];
    end
  end

  // Reset and resume signalling follow the written bits directly
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      port_reset_bit <= 1'b0;
      port_reset_d_reg <= 1'b0;
      port_resume_bit <= 1'b0;
    end else begin
      if (wr_pcs) begin
        port_reset_bit <= wd[uhp_pkg::PCS_RESET];
        port_resume_bit <= wd[uhp_pkg::PCS_RESUME];
      end
      port_reset_d_reg <= port_reset_bit;
    end
  end

  // Attach detect. While the host drives the lines the reading is
  // meaningless, so the last verdict is held instead of seeing SE0.
  assign attached = port_power_bit & (dp_sync_reg | dm_sync_reg);
  assign lines_driven = port_reset_bit | port_resume_bit;
  assign connect_next = (debounce_reg == CNT_LAST) ? attached : connect_state;
  assign conn_ev = ~connect_state & connect_next;
  assign disc_ev = connect_state & ~connect_next;

  // Debounce: the line must disagree for the whole window to flip state
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      debounce_reg <= '0;
    end else if (lines_driven || attached == connect_state || debounce_reg == CNT_LAST) begin
      debounce_reg <= '0;
    end else begin
      debounce_reg <= debounce_reg + CNT_W'(1);
    end
  end

  // Connect status and connect flag; a write of one clears the flag
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      connect_state <= 1'b0;
      connect_detected_flag <= 1'b0;
    end else begin
      connect_state <= lines_driven ? connect_state : connect_next;
      connect_detected_flag <= sticky(connect_detected_flag, conn_ev & ~lines_driven,
                                      wr_pcs & wd[uhp_pkg::PCS_CONN_FLAG]);
    end
  end

  // Speed is taken from the idle line at attach: DP high full, DM high low
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      enumerated_speed <= uhp_pkg::SPEED_NONE;
    end else if (!lines_driven && disc_ev) begin
      enumerated_speed <= uhp_pkg::SPEED_NONE;
    end else if (!lines_driven && conn_ev) begin
      enumerated_speed <= dp_sync_reg ? uhp_pkg::SPEED_FULL : uhp_pkg::SPEED_LOW;
    end
  end

  // Port enable: only the end of reset signalling can set it
  assign reset_done = port_reset_d_reg & ~port_reset_bit & connect_state;
  always_comb begin
    enable_next = port_enable_bit;
    if (reset_done) begin
      enable_next = 1'b1;
    end
    if ((disc_ev && !lines_driven) || !port_power_bit || (wr_pcs && wd[uhp_pkg::PCS_ENABLE])) begin
      enable_next = 1'b0;
    end
  end
  assign enchg_ev = enable_next ^ port_enable_bit;

  // Enable and its change flag
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      port_enable_bit <= 1'b0;
      enable_change_flag <= 1'b0;
    end else begin
      port_enable_bit <= enable_next;
      enable_change_flag <= sticky(enable_change_flag, enchg_ev,
                                   wr_pcs & wd[uhp_pkg::PCS_EN_CHANGE]);
    end
  end

  // Remote wakeup is a K state from the device while suspended
  assign wake_ev = port_suspend_bit & ~lines_driven &
                   ((enumerated_speed == uhp_pkg::SPEED_LOW) ? (dp_sync_reg & ~dm_sync_reg)
                                                              : (dm_sync_reg & ~dp_sync_reg));

  // Suspend: software sets it, only port events clear it; a zero write is ignored
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      port_suspend_bit <= 1'b0;
    end else if (port_reset_bit || port_resume_bit || wake_ev || disc_ev) begin
      port_suspend_bit <= 1'b0;
    end else if (wr_pcs && wd[uhp_pkg::PCS_SUSPEND]) begin
      port_suspend_bit <= 1'b1;
    end
  end

  // Frame starts only run on an enabled, awake port
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      SOF_ENABLE <= 1'b0;
    end else begin
      SOF_ENABLE <= port_enable_bit & ~port_suspend_bit & ~port_reset_bit;
    end
  end

  // Registered copies of the port controls for the transceiver
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      PORT_RESET_DRV <= 1'b0;
      PORT_RESUME_DRV <= 1'b0;
      PORT_POWERED <= 1'b0;
    end else begin
      PORT_RESET_DRV <= port_reset_bit;
      PORT_RESUME_DRV <= port_resume_bit;
      PORT_POWERED <= port_power_bit;
    end
  end

  // Global port flag is a level while any port flag stands
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      HOST_PORT_FLAG <= 1'b0;
    end else begin
      HOST_PORT_FLAG <= port_reset_bit | enable_change_flag | connect_detected_flag;
    end
  end

  // Interrupt events, each a one-cycle pulse
  always_comb begin
    ev = '0;
    ev[uhp_pkg::EV_CONNECT] = conn_ev & ~lines_driven;
    ev[uhp_pkg::EV_DISCONNECT] = disc_ev & ~lines_driven;
    ev[uhp_pkg::EV_EN_CHANGE] = enchg_ev;
    ev[uhp_pkg::EV_WAKEUP] = wake_ev;
    ev[uhp_pkg::EV_CHANNEL] = HOST_CH_FLAG & ~ch_flag_d_reg;
  end

  // Sticky status, write one to clear; set wins in the same cycle
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      irq_status_reg <= uhp_pkg::NUM_EV'(uhp_pkg::RST_IRQ);
    end else begin
      for (int i = 0; i < uhp_pkg::NUM_EV; i++) begin
        irq_status_reg[i] <= sticky(irq_status_reg[i], ev[i], wr_status & wd[i]);
      end
    end
  end

  // Interrupt mask
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      irq_mask_reg <= uhp_pkg::NUM_EV'(uhp_pkg::RST_IRQ);
    end else if (wr_mask) begin
      irq_mask_reg <= wd[uhp_pkg::NUM_EV-1:0];
    end
  end

  // One level interrupt, a cycle behind the status
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_status_reg & irq_mask_reg);
    end
  end
endmodule
`default_nettype wire

/* File: verif/uhp_top_properties.sv */
`timescale 1ns/10ps
`default_nettype none
// Port-level checks of the host port block, all in the system clock domain
module uhp_chk #(
  parameter int NUM_CH = 8
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic S_AXI_ARREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [NUM_CH-1:0] CH_IRQ,
  input wire logic PORT_RESET_DRV,
  input wire logic PORT_POWERED,
  input wire logic SOF_ENABLE,
  input wire logic HOST_CH_FLAG,
  input wire logic HOST_PORT_FLAG
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // Answers stand until the master takes them
  property p_b_hold;
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  // One read at a time
  property p_ar_block;
    S_AXI_RVALID |-> !S_AXI_ARREADY;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken early");
  // Channel flag needs a raised channel two edges earlier
  property p_ch_rise;
    $rose(HOST_CH_FLAG) |-> $past(CH_IRQ, 2) != '0;
  endproperty
  a_ch_rise: assert property (p_ch_rise) else $error("channel flag without source");
  property p_ch_zero;
    $past(CH_IRQ) == '0 && $past(CH_IRQ, 2) == '0 |-> !HOST_CH_FLAG;
  endproperty
  a_ch_zero: assert property (p_ch_zero) else $error("channel flag stuck");
  // Frames stop during reset signalling
  property p_rst_sof;
    PORT_RESET_DRV && $past(PORT_RESET_DRV) |-> !SOF_ENABLE;
  endproperty
  a_rst_sof: assert property (p_rst_sof) else $error("frames during reset");
  property p_rst_flag;
    PORT_RESET_DRV |-> HOST_PORT_FLAG || $past(HOST_PORT_FLAG);
  endproperty
  a_rst_flag: assert property (p_rst_flag) else $error("port flag low in reset");
  // An unpowered port cannot stay enabled
  property p_pwr_sof;
    !PORT_POWERED [*3] |-> !SOF_ENABLE;
  endproperty
  a_pwr_sof: assert property (p_pwr_sof) else $error("frames while unpowered");
endmodule
bind uhp_top uhp_chk #(.NUM_CH(NUM_CH)) u_chk (.CLK_SYS, .RST, .S_AXI_ARREADY, .S_AXI_BRESP,
  .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_RDATA, .S_AXI_RVALID, .S_AXI_RREADY, .CH_IRQ,
  .PORT_RESET_DRV, .PORT_POWERED, .SOF_ENABLE, .HOST_CH_FLAG, .HOST_PORT_FLAG);
`default_nettype wire

/* File: verif/uhp_dev_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Attached device as seen on the data lines; host pull-downs give SE0 when absent
module uhp_dev_model (
  input wire logic rst_drv,
  input wire logic resume_drv,
  output logic dp,
  output logic dm
);
  logic [1:0] idle_reg = 2'h0;
  logic low_reg = 1'b0;
  // Host signalling overrides the idle state the device shows
  always_comb begin
    {dm, dp} = idle_reg;
    if (rst_drv) {dm, dp} = 2'h0;
    else if (resume_drv) {dm, dp} = low_reg ? 2'h1 : 2'h2;
  end
  // Idle J is DP high at full speed, DM high at low speed
  // Line changes land after the edge so the host never races them
  task automatic attach(input logic low);
    low_reg <= low;
    idle_reg <= low ? 2'h2 : 2'h1;
  endtask
  task automatic detach();
    idle_reg <= 2'h0;
  endtask
  // Remote wakeup: the device drives K on its own
  task automatic wake();
    idle_reg <= low_reg ? 2'h1 : 2'h2;
  endtask
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic CLK_SYS = 1'b0;
  logic RST = 1'b1;
  logic [11:0] awa = 12'h0, ara = 12'h0;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0] ws = 4'hf;
  logic [7:0] ch = 8'h0;
  logic [7:0] en;
  logic awr, wrd, bv, arr, rv, rst_drv, res_drv, pwr, sof, chf, ptf, irq, dp, dm;
  logic [1:0] br, rr, r;
  logic [31:0] rdat, d;
  int failures = 0, comparisons = 0, cyc = 0;
  always #25 CLK_SYS = ~CLK_SYS;
  // Short debounce keeps attach and detach quick
  uhp_top #(.DEBOUNCE_CYC(8)) dut (.CLK_SYS(CLK_SYS), .RST(RST), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bre), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre),
    .CH_IRQ(ch), .DP_IN(dp), .DM_IN(dm), .PORT_RESET_DRV(rst_drv), .PORT_RESUME_DRV(res_drv),
    .PORT_POWERED(pwr), .SOF_ENABLE(sof), .HOST_CH_FLAG(chf), .HOST_PORT_FLAG(ptf), .IRQ(irq));
  uhp_dev_model dev (.rst_drv(rst_drv), .resume_drv(res_drv), .dp(dp), .dm(dm));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("Error t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Write; the response ready comes at a random moment to exercise stalls
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s);
    @(posedge CLK_SYS);
    awa <= a;
    wd <= v;
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      if (!bre && $urandom_range(1) == 1) bre <= 1'b1;
    end while (!(bv && bre));
    r = br;
    bre <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge CLK_SYS);
    ara <= a;
    arv <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      if (arr) arv <= 1'b0;
      if (!rre && $urandom_range(1) == 1) rre <= 1'b1;
    end while (!(rv && rre));
    d = rdat;
    r = rr;
    rre <= 1'b0;
  endtask
  task automatic pw(input logic [31:0] v);
    wr(uhp_pkg::OFF_PORT_CS, v, 4'hf);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask
  function automatic logic fl(input logic [7:0] c, input logic [7:0] m);
    return |(c & m);
  endfunction
  task automatic finish_test();
    $display("Counts: comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog against a hung handshake
  always @(posedge CLK_SYS) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      finish_test();
    end
  end
  initial begin
    void'($urandom(62));
    wt(16);
    RST <= 1'b0;
    rd(uhp_pkg::OFF_CH_SUMMARY);
    chk(d, uhp_pkg::RST_CH_SUMMARY);
    rd(uhp_pkg::OFF_CH_ENABLE);
    chk(d, uhp_pkg::RST_CH_ENABLE);
    rd(uhp_pkg::OFF_PORT_CS);
    chk(d, uhp_pkg::RST_PORT_CS);
    rd(12'h7fc);
    chk(r, uhp_pkg::RESP_DECERR);
    wr(uhp_pkg::OFF_CH_ENABLE, 32'hff, 4'h3);
    chk(r, uhp_pkg::RESP_SLVERR);
    // Random channel sources against random masks, none and all first
    for (int i = 0; i < 6; i++) begin
      en = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      wr(uhp_pkg::OFF_CH_ENABLE, {24'h0, en}, 4'hf);
      ch <= (i == 1) ? 8'hff : 8'($urandom);
      wt(3);
      chk(chf, fl(ch, en));
      wr(uhp_pkg::OFF_CH_SUMMARY, 32'hff, 4'hf);
      rd(uhp_pkg::OFF_CH_SUMMARY);
      chk(d, {24'h0, ch});
    end
    ch <= 8'h00;
    wt(3);
    rd(uhp_pkg::OFF_CH_SUMMARY);
    chk(d, 32'h0);
    // Bench stands in for software that has checked the bus supply first
    pw(32'h1000);
    wt(2);
    chk(pwr, 1'b1);
    // Full speed device, then low speed
    for (int k = 0; k < 2; k++) begin
      dev.attach(k[0]);
      // The flag of the earlier pass may still be seen for one edge
      do @(posedge CLK_SYS); while (!ptf);
      rd(uhp_pkg::OFF_PORT_CS);
      chk(d[1:0], 2'h3);
      chk(d[18:17], k ? uhp_pkg::SPEED_LOW : uhp_pkg::SPEED_FULL);
      chk(d[11:10], k ? 2'h2 : 2'h1);
      pw(32'h1002);
      pw(32'h1100);
      wt(2);
      chk(rst_drv, 1'b1);
      chk(ptf, 1'b1);
      pw(32'h1000);
      wt(3);
      chk(rst_drv, 1'b0);
      chk(sof, 1'b1);
      rd(uhp_pkg::OFF_PORT_CS);
      chk(d[8:2], 7'h03);
      pw(32'h1088);
      wt(2);
      chk(sof, 1'b0);
      pw(32'h1000);
      rd(uhp_pkg::OFF_PORT_CS);
      chk(d[7], 1'b1);
      // Full speed leaves suspend by resume, low speed by remote wakeup
      if (k == 0) begin
        pw(32'h1040);
        wt(1);
        chk(res_drv, 1'b1);
        pw(32'h1000);
      end else begin
        dev.wake();
        wt(4);
      end
      rd(uhp_pkg::OFF_PORT_CS);
      chk(d[7], 1'b0);
      dev.detach();
      do rd(uhp_pkg::OFF_PORT_CS); while (d[0] === 1'b1);
      chk(d[18:2], 17'h402);
      pw(32'h100a);
    end
    // Interrupt status is masked, then raises the line, then clears
    wr(uhp_pkg::OFF_IRQ_MASK, 32'h0, 4'hf);
    wt(2);
    chk(irq, 1'b0);
    wr(uhp_pkg::OFF_IRQ_MASK, 32'h1, 4'hf);
    wt(2);
    chk(irq, 1'b1);
    wr(uhp_pkg::OFF_IRQ_STATUS, 32'h1f, 4'hf);
    wt(2);
    chk(irq, 1'b0);
    finish_test();
  end
endmodule
`default_nettype wire
